// ===== core/pio_pkg.sv
// Constants for the parallel I/O port bank: line map, register offsets, reset values.
package pio_pkg;
	localparam int NUM_LINES = 33;
	localparam int PIN_IDX_W = 6;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Group codes, address bits [7:6] in the group region
	localparam logic [1:0] GRP_A = 2'h0;
	localparam logic [1:0] GRP_IN = 2'h1;
	localparam logic [1:0] GRP_C = 2'h2;
	localparam logic [1:0] GRP_D = 2'h3;
	// Line positions in the bank vector
	localparam int GRP_A_BASE = 0;
	localparam int GRP_IN_BASE = 12;
	localparam int GRP_C_BASE = 18;
	localparam int GRP_D_BASE = 21;
	localparam logic [32:0] GRP_A_MASK = 33'h000000fff;
	localparam logic [32:0] GRP_IN_MASK = 33'h00003f000;
	localparam logic [32:0] GRP_C_MASK = 33'h0001c0000;
	localparam logic [32:0] GRP_D_MASK = 33'h1ffe00000;
	localparam logic [32:0] BIDIR_MASK = 33'h1fffc0fff;
	// Per-group register offsets (group stride 0x40)
	localparam logic [5:0] OFF_OUT = 6'h00;
	localparam logic [5:0] OFF_SET = 6'h04;
	localparam logic [5:0] OFF_CLR = 6'h08;
	localparam logic [5:0] OFF_IN = 6'h0c;
	localparam logic [5:0] OFF_DIR = 6'h10;
	localparam logic [5:0] OFF_OD = 6'h14;
	localparam logic [5:0] OFF_PUEN = 6'h18;
	localparam logic [5:0] OFF_PUSEL = 6'h1c;
	localparam logic [5:0] OFF_SLEW = 6'h20;
	localparam logic [5:0] OFF_DRV = 6'h24;
	localparam logic [5:0] OFF_ALT = 6'h28;
	// Alternate routing selectors, one word each
	localparam logic [11:0] ALT_OUT_SEL_BASE = 12'h100;
	localparam logic [11:0] ALT_IN_SEL_BASE = 12'h180;
	localparam int REGION_LSB = 8;
	localparam int SELDIR_BIT = 7;
	localparam int GRP_LSB = 6;
	// Reset values
	localparam logic [32:0] RST_CFG = 33'h000000000;
	localparam logic [5:0] RST_SEL = 6'h00;
endpackage

// ===== core/pio_sync.sv
// Two-stage input synchroniser for the pin inputs.
`timescale 1ns/100ps
module pio_sync #(
	parameter int WIDTH = 33
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_meta = ce ? async_in : meta;
		next_sync_out = ce ? meta : sync_out;
	end

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end
endmodule

// ===== core/pio_alt_route.sv
// Routing of alternate functions to software-selected pins.
`timescale 1ns/100ps
module pio_alt_route #(
	parameter int NUM_ALT_OUT = 4,
	parameter int NUM_ALT_IN = 4
) (
	input wire logic [NUM_ALT_OUT-1:0] alt_out,
	input wire logic [NUM_ALT_OUT*pio_pkg::PIN_IDX_W-1:0] out_sel,
	input wire logic [NUM_ALT_IN*pio_pkg::PIN_IDX_W-1:0] in_sel,
	input wire logic [pio_pkg::NUM_LINES-1:0] pin_sync,
	output logic [pio_pkg::NUM_LINES-1:0] alt_pin_val,
	output logic [NUM_ALT_IN-1:0] alt_in_val
);
	always_comb begin
		alt_pin_val = '0;
		// Lowest-numbered function wins when two pick the same pin
		for (int k = NUM_ALT_OUT - 1; k >= 0; k--) begin
			for (int p = 0; p < pio_pkg::NUM_LINES; p++) begin
				if (out_sel[k*pio_pkg::PIN_IDX_W +: pio_pkg::PIN_IDX_W] == p[5:0]) begin
					alt_pin_val[p] = alt_out[k];
				end
			end
		end
		for (int k = 0; k < NUM_ALT_IN; k++) begin
			alt_in_val[k] = 1'b0;
			for (int p = 0; p < pio_pkg::NUM_LINES; p++) begin
				if (in_sel[k*pio_pkg::PIN_IDX_W +: pio_pkg::PIN_IDX_W] == p[5:0]) begin
					alt_in_val[k] = pin_sync[p];
				end
			end
		end
	end
endmodule

// ===== core/pio_bank.sv
// Parallel I/O port bank top: APB register file, pad control and alternate routing.
`timescale 1ns/100ps
module pio_bank #(
	parameter int NUM_ALT_OUT = 4,
	parameter int NUM_ALT_IN = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pio_pkg::ADDR_W-1:0] paddr,
	input wire logic [pio_pkg::DATA_W-1:0] pwdata,
	output logic [pio_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pio_pkg::NUM_LINES-1:0] pin_in,
	output logic [pio_pkg::NUM_LINES-1:0] pin_out,
	output logic [pio_pkg::NUM_LINES-1:0] pin_oe_n,
	output logic [pio_pkg::NUM_LINES-1:0] pull_up_en,
	output logic [pio_pkg::NUM_LINES-1:0] pull_dn_en,
	output logic [pio_pkg::NUM_LINES-1:0] slew_fast,
	output logic [pio_pkg::NUM_LINES-1:0] drive_strong,
	input wire logic [NUM_ALT_OUT-1:0] alt_out,
	output logic [NUM_ALT_IN-1:0] alt_in
);
	localparam int SW = pio_pkg::PIN_IDX_W;

	// Configuration state, one bit per line
	logic [32:0] reg_out;
	logic [32:0] reg_dir;
	logic [32:0] reg_od;
	logic [32:0] reg_puen;
	logic [32:0] reg_pusel;
	logic [32:0] reg_slew;
	logic [32:0] reg_drv;
	logic [32:0] reg_alt;
	logic [32:0] next_reg_out;
	logic [32:0] next_reg_dir;
	logic [32:0] next_reg_od;
	logic [32:0] next_reg_puen;
	logic [32:0] next_reg_pusel;
	logic [32:0] next_reg_slew;
	logic [32:0] next_reg_drv;
	logic [32:0] next_reg_alt;
	// Alternate function pin selectors, one field per function
	logic [NUM_ALT_OUT*SW-1:0] out_sel;
	logic [NUM_ALT_OUT*SW-1:0] next_out_sel;
	logic [NUM_ALT_IN*SW-1:0] in_sel;
	logic [NUM_ALT_IN*SW-1:0] next_in_sel;
	// Bus answer
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	// Pin side
	logic [32:0] pin_sync;
	logic [32:0] alt_pin_val;
	logic [NUM_ALT_IN-1:0] alt_in_val;
	logic [32:0] line_val;
	logic [32:0] line_drive;
	logic [32:0] line_low;
	logic [32:0] next_pin_out;
	logic [32:0] next_pin_oe_n;
	logic [32:0] next_pull_up_en;
	logic [32:0] next_pull_dn_en;
	logic [32:0] next_slew_fast;
	logic [32:0] next_drive_strong;
	logic [NUM_ALT_IN-1:0] next_alt_in;

	// Mask of the lines belonging to a group
	function automatic logic [32:0] grp_mask(input logic [1:0] g);
		case (g)
			pio_pkg::GRP_A: grp_mask = pio_pkg::GRP_A_MASK;
			pio_pkg::GRP_IN: grp_mask = pio_pkg::GRP_IN_MASK;
			pio_pkg::GRP_C: grp_mask = pio_pkg::GRP_C_MASK;
			default: grp_mask = pio_pkg::GRP_D_MASK;
		endcase
	endfunction

	function automatic int grp_base(input logic [1:0] g);
		case (g)
			pio_pkg::GRP_A: grp_base = pio_pkg::GRP_A_BASE;
			pio_pkg::GRP_IN: grp_base = pio_pkg::GRP_IN_BASE;
			pio_pkg::GRP_C: grp_base = pio_pkg::GRP_C_BASE;
			default: grp_base = pio_pkg::GRP_D_BASE;
		endcase
	endfunction

	// Group field of a bank vector, right-aligned
	function automatic logic [31:0] grp_get(input logic [32:0] v, input logic [1:0] g);
		logic [32:0] t;
		t = (v & grp_mask(g)) >> grp_base(g);
		grp_get = t[31:0];
	endfunction

	// Word placed on the group's lines
	function automatic logic [32:0] grp_put(input logic [31:0] w, input logic [1:0] g);
		logic [32:0] s;
		s = {1'b0, w} << grp_base(g);
		grp_put = s & grp_mask(g);
	endfunction

	// Replace only the group's bits that are configurable
	function automatic logic [32:0] grp_write(input logic [32:0] v, input logic [31:0] w,
			input logic [1:0] g, input logic [32:0] allowed);
		logic [32:0] m;
		m = grp_mask(g) & allowed;
		grp_write = (v & ~m) | (grp_put(w, g) & m);
	endfunction

	// Pin inputs are synchronised before any use
	pio_sync #(
		.WIDTH(pio_pkg::NUM_LINES)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// Alternate functions reach pins chosen by software
	pio_alt_route #(
		.NUM_ALT_OUT(NUM_ALT_OUT),
		.NUM_ALT_IN(NUM_ALT_IN)
	) u_route (
		.alt_out(alt_out),
		.out_sel(out_sel),
		.in_sel(in_sel),
		.pin_sync(pin_sync),
		.alt_pin_val(alt_pin_val),
		.alt_in_val(alt_in_val)
	);

	// APB decode and register updates
	always_comb begin
		logic [1:0] g;
		logic [5:0] off;
		logic sel_region, sel_in, hit;
		logic [4:0] idx;
		logic [31:0] rd;
		logic acc_first;
		logic acc_done;
		g = paddr[pio_pkg::GRP_LSB +: 2];
		off = {paddr[5:2], 2'b00};
		sel_region = paddr[pio_pkg::REGION_LSB];
		sel_in = paddr[pio_pkg::SELDIR_BIT];
		idx = paddr[6:2];
		acc_first = psel && penable && !pready;
		acc_done = psel && penable && pready;
		hit = 1'b0;
		rd = '0;
		next_reg_out = reg_out;
		next_reg_dir = reg_dir;
		next_reg_od = reg_od;
		next_reg_puen = reg_puen;
		next_reg_pusel = reg_pusel;
		next_reg_slew = reg_slew;
		next_reg_drv = reg_drv;
		next_reg_alt = reg_alt;
		next_out_sel = out_sel;
		next_in_sel = in_sel;
		next_prdata = prdata;
		next_pready = pready;
		next_pslverr = pslverr;
		if (paddr[pio_pkg::ADDR_W-1:pio_pkg::REGION_LSB+1] == '0) begin
			if (!sel_region) begin
				hit = 1'b1;
				case (off)
					pio_pkg::OFF_OUT: rd = grp_get(reg_out, g);
					pio_pkg::OFF_SET: rd = '0;
					pio_pkg::OFF_CLR: rd = '0;
					pio_pkg::OFF_IN: rd = grp_get(pin_sync, g);
					pio_pkg::OFF_DIR: rd = grp_get(reg_dir, g);
					pio_pkg::OFF_OD: rd = grp_get(reg_od, g);
					pio_pkg::OFF_PUEN: rd = grp_get(reg_puen, g);
					pio_pkg::OFF_PUSEL: rd = grp_get(reg_pusel, g);
					pio_pkg::OFF_SLEW: rd = grp_get(reg_slew, g);
					pio_pkg::OFF_DRV: rd = grp_get(reg_drv, g);
					pio_pkg::OFF_ALT: rd = grp_get(reg_alt, g);
					default: hit = 1'b0;
				endcase
			end else if (!sel_in && int'(idx) < NUM_ALT_OUT) begin
				hit = 1'b1;
				rd = {26'h0, out_sel[idx*SW +: SW]};
			end else if (sel_in && int'(idx) < NUM_ALT_IN) begin
				hit = 1'b1;
				rd = {26'h0, in_sel[idx*SW +: SW]};
			end
		end
		if (acc_first) begin
			// One wait state, then the answer
			next_pready = 1'b1;
			next_pslverr = !hit;
			next_prdata = (pwrite || !hit) ? 32'h00000000 : rd;
		end else if (acc_done) begin
			// Write lands at the edge where the answer is sampled
			next_pready = 1'b0;
			next_pslverr = 1'b0;
			if (pwrite && hit && !sel_region) begin
				case (off)
					pio_pkg::OFF_OUT: next_reg_out = grp_write(reg_out, pwdata, g,
						pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_SET: next_reg_out = reg_out
						| (grp_put(pwdata, g) & pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_CLR: next_reg_out = reg_out
						& ~(grp_put(pwdata, g) & pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_DIR: next_reg_dir = grp_write(reg_dir, pwdata, g,
						pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_OD: next_reg_od = grp_write(reg_od, pwdata, g,
						pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_PUEN: next_reg_puen = grp_write(reg_puen, pwdata, g,
						pio_pkg::BIDIR_MASK | pio_pkg::GRP_IN_MASK);
					pio_pkg::OFF_PUSEL: next_reg_pusel = grp_write(reg_pusel, pwdata, g,
						pio_pkg::BIDIR_MASK | pio_pkg::GRP_IN_MASK);
					pio_pkg::OFF_SLEW: next_reg_slew = grp_write(reg_slew, pwdata, g,
						pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_DRV: next_reg_drv = grp_write(reg_drv, pwdata, g,
						pio_pkg::BIDIR_MASK);
					pio_pkg::OFF_ALT: next_reg_alt = grp_write(reg_alt, pwdata, g,
						pio_pkg::BIDIR_MASK);
					default: next_reg_out = reg_out;
				endcase
			end else if (pwrite && hit && !sel_in) begin
				next_out_sel[idx*SW +: SW] = pwdata[SW-1:0];
			end else if (pwrite && hit) begin
				next_in_sel[idx*SW +: SW] = pwdata[SW-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_out <= pio_pkg::RST_CFG;
			reg_dir <= pio_pkg::RST_CFG;
			reg_od <= pio_pkg::RST_CFG;
			reg_puen <= pio_pkg::RST_CFG;
			reg_pusel <= pio_pkg::RST_CFG;
			reg_slew <= pio_pkg::RST_CFG;
			reg_drv <= pio_pkg::RST_CFG;
			reg_alt <= pio_pkg::RST_CFG;
			out_sel <= {NUM_ALT_OUT{pio_pkg::RST_SEL}};
			in_sel <= {NUM_ALT_IN{pio_pkg::RST_SEL}};
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			// Held frozen while the clock enable is low
			reg_out <= next_reg_out;
			reg_dir <= next_reg_dir;
			reg_od <= next_reg_od;
			reg_puen <= next_reg_puen;
			reg_pusel <= next_reg_pusel;
			reg_slew <= next_reg_slew;
			reg_drv <= next_reg_drv;
			reg_alt <= next_reg_alt;
			out_sel <= next_out_sel;
			in_sel <= next_in_sel;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Pad control from configuration
	always_comb begin
		// Alternate function value on lines given to it, GPIO value elsewhere
		line_val = (reg_alt & alt_pin_val) | (~reg_alt & reg_out);
		// Only bidirectional lines set as outputs may drive at all
		line_drive = reg_dir & pio_pkg::BIDIR_MASK;
		// Open-drain lines drive only a low, never a high
		line_low = ~reg_od | ~line_val;
		next_pin_oe_n = ~(line_drive & line_low);
		next_pin_out = line_val & ~reg_od & line_drive;
		next_pull_up_en = reg_puen & reg_pusel;
		next_pull_dn_en = reg_puen & ~reg_pusel;
		next_slew_fast = reg_slew & pio_pkg::BIDIR_MASK;
		next_drive_strong = reg_drv & pio_pkg::BIDIR_MASK;
		next_alt_in = alt_in_val;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			pull_up_en <= '0;
			pull_dn_en <= '0;
			slew_fast <= '0;
			drive_strong <= '0;
			alt_in <= '0;
		end else if (ce) begin
			// Pads also hold while the clock enable is low
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			pull_up_en <= next_pull_up_en;
			pull_dn_en <= next_pull_dn_en;
			slew_fast <= next_slew_fast;
			drive_strong <= next_drive_strong;
			alt_in <= next_alt_in;
		end
	end
endmodule

// ===== verif/pio_bank_sva.sv
// Port checker for the parallel I/O port bank.
`timescale 1ns/100ps
module pio_bank_chk #(
	parameter int NUM_ALT_OUT = 4,
	parameter int NUM_ALT_IN = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [32:0] pin_in,
	input wire logic [32:0] pin_out,
	input wire logic [32:0] pin_oe_n,
	input wire logic [32:0] pull_up_en,
	input wire logic [32:0] pull_dn_en,
	input wire logic [32:0] slew_fast,
	input wire logic [32:0] drive_strong,
	input wire logic [NUM_ALT_OUT-1:0] alt_out,
	input wire logic [NUM_ALT_IN-1:0] alt_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reset_state_a: assert property ($rose(presetn) |-> &pin_oe_n && (pin_out | pull_up_en | pull_dn_en) == 33'h0)
		else $error("pads not idle after reset");
	input_only_a: assert property (&pin_oe_n[17:12] && !(|{slew_fast[17:12], drive_strong[17:12]}))
		else $error("input-only line driven");
	drive_oe_a: assert property ((pin_out & pin_oe_n) == 33'h0)
		else $error("high driven on disabled pad");
	pull_excl_a: assert property ((pull_up_en & pull_dn_en) == 33'h0)
		else $error("both pulls on");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_wait_a: assert property (psel && $rose(penable) |=> pready)
		else $error("ready not one cycle after access");
	err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("data on refused access");
	pad_follow_a: assert property ($changed(slew_fast) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("pad changed without write");
	cover property (pready && pwrite);
	cover property (pready && pslverr);
	cover property (|alt_in);
endmodule

// ===== verif/pio_board.sv
// Board model: pin levels from pad drive, board sources and pulls.
`timescale 1ns/100ps
module pio_board (
	input wire logic pclk,
	input wire logic [32:0] pin_out,
	input wire logic [32:0] pin_oe_n,
	input wire logic [32:0] pull_up_en,
	input wire logic [32:0] pull_dn_en,
	input wire logic [32:0] ext_val,
	input wire logic [32:0] ext_en,
	output logic [32:0] pin_in
);
	logic [32:0] wobble = 33'h0;
	always @(posedge pclk) wobble <= ~wobble;
	// Floating lines wobble each cycle
	always_comb begin
		for (int i = 0; i < 33; i++) begin
			if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (pull_up_en[i] | pull_dn_en[i]) pin_in[i] = pull_up_en[i];
			else pin_in[i] = wobble[i];
		end
	end
endmodule

// ===== verif/parallel_io_port_bank_test.sv
// Self-checking bench for the parallel I/O port bank.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module parallel_io_port_bank_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv, d, o;
	logic pready, pslverr, ev;
	logic [32:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_dn_en, slew_fast, drive_strong;
	logic [3:0] alt_out = 4'h0;
	logic [3:0] alt_in;
	logic [32:0] ext_val = 33'h0;
	logic [32:0] ext_en = {33{1'b1}};
	int n_errors = 0;
	int n_checks = 0;
	int seed = 32'h901f;
	int cyc = 0;
	int g;
	int base[4] = '{0, 12, 18, 21};
	int wid[4] = '{12, 6, 3, 12};
	pio_bank #(.NUM_ALT_OUT(4), .NUM_ALT_IN(4)) pio_bank_inst (.*);
	pio_board pio_board_inst (.*);
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	function automatic logic [11:0] ad(input int gr, input logic [5:0] off);
		return 12'(gr * 64) + 12'(off);
	endfunction
	function automatic logic [31:0] sl(input logic [32:0] v, input int gr);
		return 32'((v >> base[gr]) & ~(33'h1ffffffff << wid[gr]));
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(t, 2)
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(pin_oe_n, {33{1'b1}})
		`CHK(pull_up_en | pull_dn_en | pin_out, 33'h0)
		for (int i = 0; i < 12; i++) begin
			g = i % 4;
			d = $random(seed);
			o = $random(seed);
			ext_val <= 33'({$random(seed), $random(seed)});
			apb(1'b1, ad(g, pio_pkg::OFF_OUT), o);
			apb(1'b1, ad(g, pio_pkg::OFF_DIR), d);
			repeat (4) @(posedge pclk);
			if (g == 1) d = 32'h0;
			`CHK(sl(pin_oe_n, g), sl({33{1'b1}}, g) & ~d)
			`CHK(sl(pin_out, g), sl({33{1'b1}}, g) & d & o)
			apb(1'b0, ad(g, pio_pkg::OFF_IN), 32'h0);
			`CHK(rv, (d & o | ~d & sl(ext_val, g)) & sl({33{1'b1}}, g))
		end
		apb(1'b1, ad(3, pio_pkg::OFF_OUT), 32'h0f0);
		apb(1'b1, ad(3, pio_pkg::OFF_SET), 32'h801);
		apb(1'b1, ad(3, pio_pkg::OFF_CLR), 32'h010);
		apb(1'b0, ad(3, pio_pkg::OFF_OUT), 32'h0);
		`CHK(rv, 32'h8e1)
		apb(1'b0, ad(3, pio_pkg::OFF_SET), 32'h0);
		`CHK(rv, 32'h0)
		d = $random(seed);
		o = $random(seed);
		apb(1'b1, ad(0, pio_pkg::OFF_PUEN), d);
		apb(1'b1, ad(0, pio_pkg::OFF_PUSEL), o);
		apb(1'b1, ad(0, pio_pkg::OFF_SLEW), o);
		apb(1'b1, ad(0, pio_pkg::OFF_DRV), d);
		repeat (3) @(posedge pclk);
		`CHK(sl(pull_up_en, 0), d & o & 32'hfff)
		`CHK(sl(pull_dn_en, 0), d & ~o & 32'hfff)
		`CHK(sl(slew_fast, 0), o & 32'hfff)
		`CHK(sl(drive_strong, 0), d & 32'hfff)
		ext_en[11:0] <= 12'h000;
		apb(1'b1, ad(0, pio_pkg::OFF_DIR), 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, ad(0, pio_pkg::OFF_IN), 32'h0);
		`CHK(rv & d & 32'hfff, d & o & 32'hfff)
		ext_en <= {33{1'b1}};
		apb(1'b1, ad(2, pio_pkg::OFF_DIR), 32'h7);
		apb(1'b1, ad(2, pio_pkg::OFF_OUT), 32'h5);
		apb(1'b1, ad(2, pio_pkg::OFF_OD), 32'h7);
		repeat (3) @(posedge pclk);
		`CHK(sl(pin_oe_n, 2), 32'h5)
		`CHK(sl(pin_out, 2), 32'h0)
		apb(1'b1, ad(0, pio_pkg::OFF_DIR), 32'h8);
		apb(1'b1, ad(0, pio_pkg::OFF_OUT), 32'h0);
		apb(1'b1, ad(0, pio_pkg::OFF_ALT), 32'h8);
		apb(1'b1, 12'h100, 32'h3);
		apb(1'b1, 12'h184, 32'he);
		apb(1'b0, 12'h184, 32'h0);
		`CHK(rv, 32'he)
		for (int k = 0; k < 2; k++) begin
			alt_out <= 4'(k);
			ext_val[14] <= k[0];
			repeat (4) @(posedge pclk);
			`CHK(pin_out[3], k[0])
			`CHK(alt_in[1], k[0])
		end
		ce <= 1'b0;
		alt_out <= 4'h0;
		ext_val[14] <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK(pin_out[3], 1'b1)
		`CHK(alt_in[1], 1'b1)
		ce <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK(pin_out[3], 1'b0)
		`CHK(alt_in[1], 1'b0)
		alt_out <= 4'h1;
		apb(1'b1, ad(0, pio_pkg::OFF_ALT), 32'h0);
		repeat (2) @(posedge pclk);
		`CHK(pin_out[3], 1'b0)
		apb(1'b0, 12'h02c, 32'h0);
		`CHK({ev, rv}, 33'h100000000)
		apb(1'b1, 12'h200, 32'hffffffff);
		`CHK(ev, 1'b1)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(pin_oe_n, {33{1'b1}})
		`CHK(pull_up_en | pull_dn_en | pin_out, 33'h0)
		presetn <= 1'b1;
		apb(1'b0, ad(2, pio_pkg::OFF_DIR), 32'h0);
		`CHK(rv, 32'h0)
		report_and_stop();
	end
endmodule
bind pio_bank pio_bank_chk #(.NUM_ALT_OUT(NUM_ALT_OUT), .NUM_ALT_IN(NUM_ALT_IN)) pio_bank_chk_inst (.*);
